/* src/cycle_counter_map.vh */
// Purpose: constants for the power-cycle counter and enable switch block
// Assumes: 20 MHz clock, 50 ns period
// Notes: times in ns, cycle counts derived below
// How it works
// - after power-up the enable switch is off and the output floats.
// - switch turns on after 63 consecutive periods longer than disable interval.
// - any period shorter than disable interval clears the consecutive count.
// - while on, 32 cumulative periods shorter than enable interval turn it off.
// - while on, long periods leave the cumulative count unchanged.
// - wake-up events never touch the switch or either count.
// - cumulative count keeps earlier history, so re-enable may be immediate.
// - period is time between successive power-cycle detect pulses.
// - wake asserts on droop comparator report in both switch states.
// - enable output is open drain: on pulls low, off floats.
// - detect pulse only after wake low longer than a minimum, at rise.
// - wake pulses repeat until a power cycle is detected or undervoltage.
// - everything held disabled until supply passes turn-on threshold.
`ifndef CYCLE_COUNTER_MAP_VH
`define CYCLE_COUNTER_MAP_VH
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 50
`define DISABLE_INTERVAL_NS 177000
`define ENABLE_INTERVAL_NS 57000
`define DISABLE_INTERVAL_CYC ((`DISABLE_INTERVAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENABLE_INTERVAL_CYC (`ENABLE_INTERVAL_NS / `CLK_PERIOD_NS)
`define LOW_MIN_NS 500
`define LOW_MIN_CYC ((`LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_PULSE_NS 1000
`define WAKE_PULSE_CYC (`WAKE_PULSE_NS / `CLK_PERIOD_NS)
`define WAKE_REPEAT_NS 30303
`define WAKE_REPEAT_CYC (`WAKE_REPEAT_NS / `CLK_PERIOD_NS)
// ****************************************
// counts and widths
// ****************************************
`define DISABLE_COUNT 63
`define ENABLE_COUNT 32
`define TIMER_W 16
`define CNT_W 6
`define WAKE_W 10
`endif

/* src/pcd_detector.v */
// Purpose: turns the wake-line level compare into power-cycle detect pulses
// Assumes: wake_low_i synchronous, high while wake line under detect threshold
// Notes: arms after a long enough low, fires on the rise
`timescale 1ns/1ps
`default_nettype none
`include "cycle_counter_map.vh"
module power_cycle_detector (
  // clock, reset and enable
  input wire clk_i,
  input wire rstn_i,
  input wire enable_i,
  // line
  input wire wake_low_i,
  output reg power_cycle_detect_o
);
  // cut the 32-bit constant to the counter width on purpose
  localparam [31:0] LOW_MIN_W = `LOW_MIN_CYC;
  localparam [5:0] LOW_MIN = LOW_MIN_W[5:0];
  reg [5:0] low_cnt_q;
  reg armed_q;
  // ****************************************
  // arm on long low, pulse on rise
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_q <= 6'h00;
      armed_q <= 1'b0;
      power_cycle_detect_o <= 1'b0;
    end else if (!enable_i) begin
      low_cnt_q <= 6'h00;
      armed_q <= 1'b0;
      power_cycle_detect_o <= 1'b0;
    end else begin
      power_cycle_detect_o <= 1'b0;
      if (wake_low_i) begin
        if (low_cnt_q < LOW_MIN) begin
          low_cnt_q <= low_cnt_q + 6'h01;
        end else begin
          armed_q <= 1'b1;
        end
      end else begin
        low_cnt_q <= 6'h00;
        armed_q <= 1'b0;
        power_cycle_detect_o <= armed_q;
      end
    end
  end
endmodule
`default_nettype wire

/* src/power_cycle_counter_enable_switch.v */
// Purpose: period measurement, enable switch and wake pulse control
// Assumes: uvlo_ok_i high above supply turn-on, low below turn-off
// Notes: open-drain outputs are driven only toward ground
`timescale 1ns/1ps
`default_nettype none
`include "cycle_counter_map.vh"
module power_cycle_counter_enable_switch #(
  // qualifying intervals in clock cycles, enable below disable
  parameter [31:0] DISABLE_INTERVAL = `DISABLE_INTERVAL_CYC,
  parameter [31:0] ENABLE_INTERVAL = `ENABLE_INTERVAL_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // analog front end
  input wire uvlo_ok_i,
  input wire wake_low_i,
  input wire droop_i,
  // enable switch, open drain
  output wire secondary_enable_out_o,
  output wire secondary_enable_out_oe_o,
  // wake switch, open drain
  output wire wake_out_o,
  output wire wake_oe_o,
  // status
  output wire power_cycle_detect_o
);
  // 32-bit constants, cut to the counter widths on purpose below
  localparam [31:0] DIS_CNT_W = `DISABLE_COUNT;
  localparam [31:0] ENA_CNT_W = `ENABLE_COUNT;
  localparam [31:0] WAKE_ON_W = `WAKE_PULSE_CYC;
  localparam [31:0] WAKE_PER_W = `WAKE_REPEAT_CYC;
  localparam [`TIMER_W-1:0] DIS_CYC = DISABLE_INTERVAL[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] ENA_CYC = ENABLE_INTERVAL[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] TIMER_MAX = {`TIMER_W{1'b1}};
  localparam [`CNT_W-1:0] DIS_CNT = DIS_CNT_W[`CNT_W-1:0];
  localparam [`CNT_W-1:0] ENA_CNT = ENA_CNT_W[`CNT_W-1:0];
  localparam [`WAKE_W-1:0] WAKE_ON = WAKE_ON_W[`WAKE_W-1:0];
  localparam [`WAKE_W-1:0] WAKE_PER = WAKE_PER_W[`WAKE_W-1:0];
  reg rst_s1_q;
  reg rst_n;
  reg [`TIMER_W-1:0] timer_q;
  reg seen_q;
  reg [`CNT_W-1:0] dis_cnt_q;
  reg [`CNT_W-1:0] ena_cnt_q;
  reg switch_on_q;
  reg waking_q;
  reg [`WAKE_W-1:0] wake_cnt_q;
  reg wake_drv_q;
  wire en;
  assign en = uvlo_ok_i;
  // ****************************************
  // reset release
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
  // detector
  power_cycle_detector power_cycle_detector_i (
    .clk_i(clk_i),
    .rstn_i(rst_n),
    .enable_i(en),
    .wake_low_i(wake_low_i),
    .power_cycle_detect_o(power_cycle_detect_o)
  );
  // ****************************************
  // period timer, saturating
  // ****************************************
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= {`TIMER_W{1'b0}};
      seen_q <= 1'b0;
    end else if (!en) begin
      timer_q <= {`TIMER_W{1'b0}};
      seen_q <= 1'b0;
    end else if (power_cycle_detect_o) begin
      // starts at one so the value seen at the next pulse is the full period
      timer_q <= {{(`TIMER_W-1){1'b0}}, 1'b1};
      seen_q <= 1'b1;
    end else if (timer_q != TIMER_MAX) begin
      timer_q <= timer_q + {{(`TIMER_W-1){1'b0}}, 1'b1};
    end
  end
  // ****************************************
  // disable and re-enable counters
  // ****************************************
  // wake logic has no path into these counters
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dis_cnt_q <= {`CNT_W{1'b0}};
      ena_cnt_q <= {`CNT_W{1'b0}};
      switch_on_q <= 1'b0;
    end else if (!en) begin
      dis_cnt_q <= {`CNT_W{1'b0}};
      ena_cnt_q <= {`CNT_W{1'b0}};
      switch_on_q <= 1'b0;
    end else if (power_cycle_detect_o && seen_q) begin
      if (!switch_on_q) begin
        if (timer_q > DIS_CYC) begin
          if (dis_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1} >= DIS_CNT) begin
            switch_on_q <= 1'b1;
            dis_cnt_q <= {`CNT_W{1'b0}};
          end else begin
            dis_cnt_q <= dis_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
          end
        end else begin
          dis_cnt_q <= {`CNT_W{1'b0}};
        end
      end else if (timer_q < ENA_CYC) begin
        // history kept, so a prior count can finish sooner
        if (ena_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1} >= ENA_CNT) begin
          switch_on_q <= 1'b0;
          ena_cnt_q <= {`CNT_W{1'b0}};
        end else begin
          ena_cnt_q <= ena_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // long periods while on hold the count
    end
  end
  // open drain: drive low only when on
  assign secondary_enable_out_o = 1'b0;
  assign secondary_enable_out_oe_o = switch_on_q;
  // ****************************************
  // wake pulse generator
  // ****************************************
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      waking_q <= 1'b0;
      wake_cnt_q <= {`WAKE_W{1'b0}};
      wake_drv_q <= 1'b0;
    end else if (!en || power_cycle_detect_o) begin
      waking_q <= 1'b0;
      wake_cnt_q <= {`WAKE_W{1'b0}};
      wake_drv_q <= 1'b0;
    end else if (!waking_q) begin
      if (droop_i) begin
        waking_q <= 1'b1;
        wake_cnt_q <= {`WAKE_W{1'b0}};
        wake_drv_q <= 1'b1;
      end
    end else begin
      if (wake_cnt_q >= WAKE_PER - {{(`WAKE_W-1){1'b0}}, 1'b1}) begin
        wake_cnt_q <= {`WAKE_W{1'b0}};
        wake_drv_q <= 1'b1;
      end else begin
        wake_cnt_q <= wake_cnt_q + {{(`WAKE_W-1){1'b0}}, 1'b1};
        wake_drv_q <= (wake_cnt_q + {{(`WAKE_W-1){1'b0}}, 1'b1}) < WAKE_ON;
      end
    end
  end
  assign wake_out_o = 1'b0;
  assign wake_oe_o = wake_drv_q;
endmodule
`default_nettype wire

/* test/pcc_partner.sv */
// Purpose: primary-side switching model feeding the wake comparator level
// Assumes: per_i above 20 cycles
// Notes: level idles low while stopped
`timescale 1ns/1ps
`default_nettype none
module pcc_partner (
  // control
  input wire logic clk_i,
  input wire logic run_i,
  input var int per_i,
  // wake comparator level
  output var logic wake_low_o
);
  int cnt_q = 0;
  initial wake_low_o = 1'b0;
  // 12-cycle low dwell, its end marks a power cycle
  always @(posedge clk_i) begin
    cnt_q <= (cnt_q >= per_i - 1) ? 0 : cnt_q + 1;
    wake_low_o <= run_i && (cnt_q < 12);
  end
endmodule
`default_nettype wire

/* test/pcc_chk.sv */
// Purpose: port checker for the cycle counter block
// Assumes: one clock, async active-low reset
// Notes: bound at file foot
`timescale 1ns/1ps
`default_nettype none
module pcc_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic uvlo_ok_i,
  input wire logic wake_low_i,
  input wire logic droop_i,
  input wire logic secondary_enable_out_o,
  input wire logic secondary_enable_out_oe_o,
  input wire logic wake_out_o,
  input wire logic wake_oe_o,
  input wire logic power_cycle_detect_o
);
  logic [4:0] wake_len_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // run length of the wake drive
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) wake_len_q <= 5'h00;
    else wake_len_q <= wake_oe_o ? wake_len_q + 5'h01 : 5'h00;
  end
  od_data_low_a: assert property (!secondary_enable_out_o && !wake_out_o) else $error("drain data high");
  uvlo_idle_a: assert property (!uvlo_ok_i [*3] |-> !secondary_enable_out_oe_o && !wake_oe_o)
    else $error("active under uvlo");
  detect_single_a: assert property (power_cycle_detect_o |=> !power_cycle_detect_o) else $error("detect long");
  detect_cause_a: assert property (power_cycle_detect_o |-> $past(wake_low_i, 2) || $past(wake_low_i, 3))
    else $error("detect without low dwell");
  en_rise_a: assert property ($rose(secondary_enable_out_oe_o) |->
    $past(power_cycle_detect_o) || $past(power_cycle_detect_o, 2)) else $error("switch on without detect");
  en_fall_a: assert property ($fell(secondary_enable_out_oe_o) |-> $past(power_cycle_detect_o) ||
    $past(power_cycle_detect_o, 2) || !$past(uvlo_ok_i)) else $error("switch off without cause");
  wake_start_a: assert property ($rose(droop_i) && uvlo_ok_i && !wake_oe_o |-> ##[1:3] wake_oe_o)
    else $error("no wake on droop");
  wake_len_a: assert property ($fell(wake_oe_o) |-> wake_len_q == 5'h14 ||
    $past(power_cycle_detect_o) || !$past(uvlo_ok_i)) else $error("wake pulse length");
endmodule
bind power_cycle_counter_enable_switch pcc_chk pcc_chk_i (.clk_i, .rstn_i, .uvlo_ok_i, .wake_low_i, .droop_i,
  .secondary_enable_out_o, .secondary_enable_out_oe_o, .wake_out_o, .wake_oe_o, .power_cycle_detect_o);
`default_nettype wire

/* test/power_cycle_counter_enable_switch_tb_top.sv */
// Purpose: self-checking bench for the cycle counter block
// Assumes: fixed counts 63 and 32
// Notes: intervals shortened by parameter, about 45k cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,x,g) begin samples_checked++; if ((g) !== (x)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, x, g); end end
module power_cycle_counter_enable_switch_tb_top;
  logic clk_i = 0, rstn_i = 0, uvlo_ok_i = 0, droop_i = 0, run_q = 0, oe_q = 0, e;
  wire logic wake_low, od, oe, wk, wk_oe, det;
  int per_q = 600, fail_count = 0, samples_checked = 0;
  // bench intervals in cycles, enable below disable
  localparam int DIS = 300;
  localparam int ENA = 100;
  logic q[$];
  initial forever #25 clk_i = ~clk_i;
  pcc_partner pcc_partner_i (.clk_i(clk_i), .run_i(run_q), .per_i(per_q), .wake_low_o(wake_low));
  power_cycle_counter_enable_switch #(.DISABLE_INTERVAL(DIS), .ENABLE_INTERVAL(ENA))
    power_cycle_counter_enable_switch_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .uvlo_ok_i(uvlo_ok_i), .wake_low_i(wake_low), .droop_i(droop_i), .secondary_enable_out_o(od),
    .secondary_enable_out_oe_o(oe), .wake_out_o(wk), .wake_oe_o(wk_oe), .power_cycle_detect_o(det));
  // each switch change takes the oldest note
  always @(posedge clk_i) begin
    if (rstn_i && oe !== oe_q) begin
      e = (q.size() > 0) ? q.pop_front() : oe_q;
      `CHK("enable oe", e, oe)
    end
    oe_q <= oe;
  end
  // n periods, each lo plus random span cycles
  task automatic run(input int n, input int lo, input int span);
    repeat (n) begin
      per_q <= lo + $urandom % span;
      @(posedge clk_i iff det);
    end
  endtask
  // one-cycle droop, wake switch on one edge later, checked at the next edge
  task automatic droop_pulse();
    droop_i <= 1;
    @(posedge clk_i);
    droop_i <= 0;
    @(posedge clk_i);
    `CHK("wake on", 1'b1, wk_oe)
  endtask
  task automatic end_of_test();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hD09AFED2));
    repeat (20) @(posedge clk_i);
    rstn_i <= 1;
    repeat (3) @(posedge clk_i);
    `CHK("oe after reset", 1'b0, oe)
    uvlo_ok_i <= 1;
    run_q <= 1;
    run(1, 30, 60);
    run(40, DIS + 5, 60);
    run(1, DIS, 1);
    run(30, DIS + 5, 60);
    droop_pulse();
    run(32, DIS + 5, 60);
    q.push_back(1'b1);
    run(1, DIS + 5, 60);
    repeat (5) @(posedge clk_i);
    $display("test disable done");
    run(20, 30, ENA - 30);
    run(1, ENA, 1);
    run(5, ENA, 2000);
    run_q <= 0;
    droop_pulse();
    repeat (1300) @(posedge clk_i);
    run_q <= 1;
    run(12, 30, ENA - 30);
    q.push_back(1'b0);
    run(1, 30, ENA - 30);
    repeat (5) @(posedge clk_i);
    $display("test enable done");
    uvlo_ok_i <= 0;
    droop_i <= 1;
    repeat (30) @(posedge clk_i);
    `CHK("wake idle", 1'b0, wk_oe)
    `CHK("drain data", 2'b00, {od, wk})
    `CHK("notes left", 0, q.size())
    $display("test uvlo done");
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
